// [core/epr_pkg.sv]
package epr_pkg;
    typedef logic [15:0] word16_t;
    typedef logic [31:0] word32_t;
    typedef logic [8:0] csr_addr_t;
    typedef logic [4:0] phy_addr_t;
    typedef logic [3:0] nib_t;
    typedef logic [2:0] slot_t;

    // memory-mapped byte offsets, one aligned word per register
    localparam csr_addr_t OFF_CONTROL = 9'h1C0;
    localparam csr_addr_t OFF_STATE = 9'h1C4;
    localparam csr_addr_t OFF_IDENT_HIGH = 9'h1C8;
    localparam csr_addr_t OFF_IDENT_LOW = 9'h1CC;
    localparam csr_addr_t OFF_ADVERT = 9'h1D0;
    localparam csr_addr_t OFF_PARTNER = 9'h1D4;
    localparam csr_addr_t OFF_EXPANSION = 9'h1D8;
    localparam csr_addr_t OFF_SPECIAL = 9'h1DC;

    // serial register indexes
    localparam phy_addr_t IDX_CONTROL = 5'h00;
    localparam phy_addr_t IDX_STATE = 5'h01;
    localparam phy_addr_t IDX_IDENT_HIGH = 5'h02;
    localparam phy_addr_t IDX_IDENT_LOW = 5'h03;
    localparam phy_addr_t IDX_ADVERT = 5'h04;
    localparam phy_addr_t IDX_PARTNER = 5'h05;
    localparam phy_addr_t IDX_EXPANSION = 5'h06;
    localparam phy_addr_t IDX_SPECIAL = 5'h1F;

    // storage slots behind both views
    localparam slot_t SLOT_CONTROL = 3'h0;
    localparam slot_t SLOT_STATE = 3'h1;
    localparam slot_t SLOT_IDENT_HIGH = 3'h2;
    localparam slot_t SLOT_IDENT_LOW = 3'h3;
    localparam slot_t SLOT_ADVERT = 3'h4;
    localparam slot_t SLOT_PARTNER = 3'h5;
    localparam slot_t SLOT_EXPANSION = 3'h6;
    localparam slot_t SLOT_SPECIAL = 3'h7;

    // control register bit positions, and the status negotiation-complete bit
    localparam int CTL_SOFT_RESET = 15;
    localparam int CTL_LOOP = 14;
    localparam int CTL_SPEED = 13;
    localparam int CTL_NEG_EN = 12;
    localparam int CTL_PWR_DOWN = 11;
    localparam int CTL_ISOLATE = 10;
    localparam int CTL_NEG_RESTART = 9;
    localparam int CTL_DUPLEX = 8;
    localparam int CTL_COL_TEST = 7;
    localparam int STA_NEG_DONE = 5;

    // values after reset
    localparam word16_t CONTROL_RESET = 16'h1000;
    localparam word16_t STATE_BASE = 16'h780D;
    localparam word16_t IDENT_HIGH_RESET = 16'h0000;
    localparam word16_t IDENT_LOW_RESET = 16'h0000;
    localparam word16_t ADVERT_RESET = 16'h01E1;
    localparam word16_t PARTNER_ABILITY = 16'h01E1;
    localparam word16_t EXPANSION_VALUE = 16'h0001;
    localparam word16_t SPECIAL_RESET = 16'h0000;

    // advertisement ability bits
    localparam int ADV_100_FULL = 8;
    localparam int ADV_100_HALF = 7;
    localparam int ADV_10_FULL = 6;

    // serial frame
    localparam logic [5:0] PREAMBLE_ONES = 6'h20;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [3:0] HDR_LAST = 4'hC;
    localparam logic [3:0] DATA_LAST = 4'hF;

    // emulated negotiation settling time
    localparam int CLK_PERIOD_NS = 40;
    localparam int NEG_SETTLE_NS = 200;
    localparam int NEG_SETTLE_CYC_I = (NEG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] NEG_SETTLE_CYC = NEG_SETTLE_CYC_I[7:0];
endpackage

// [core/epr_mgmt_if.sv]
`timescale 1ns/1ps
interface epr_mgmt_if;
    import epr_pkg::*;
    phy_addr_t index;
    word16_t rdData;
    logic wrStrobe;
    word16_t wrData;
    phy_addr_t strapAddr;
    logic strapValid;

    modport regs (
        input index,
        input wrStrobe,
        input wrData,
        output rdData,
        output strapAddr,
        output strapValid
    );
    modport serial (
        output index,
        output wrStrobe,
        output wrData,
        input rdData,
        input strapAddr,
        input strapValid
    );
endinterface

// [core/epr_mdio_serial.sv]
`timescale 1ns/1ps
module epr_mdio_serial (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic mdc,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe,
    epr_mgmt_if.serial bus
);
    import epr_pkg::*;

    typedef enum logic [1:0] {S_PRE, S_HDR, S_TA, S_DAT} epr_frame_t;

    epr_frame_t state;
    logic mdcPrev;
    logic [5:0] ones;
    logic [3:0] cnt;
    logic [11:0] hdr;
    logic isRead;
    phy_addr_t regIdx;
    word16_t shift;
    logic wrPulse;
    word16_t wrWord;

    wire mdcRise = mdc & ~mdcPrev;
    wire [12:0] hdrFull = {hdr, mdioIn};
    wire [1:0] hdrOp = hdrFull[11:10];
    wire hdrStartOk = hdrFull[12];
    wire hdrOpOk = (hdrOp == OP_READ) || (hdrOp == OP_WRITE);
    // anything not at our strapped address is left to other stations
    wire hdrMine = hdrStartOk && hdrOpOk && bus.strapValid && (hdrFull[9:5] == bus.strapAddr); // [RULE_02]

    assign bus.index = regIdx;
    assign bus.wrStrobe = wrPulse;
    assign bus.wrData = wrWord;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state <= S_PRE;
            mdcPrev <= 1'b0;
            ones <= 6'h00;
            cnt <= 4'h0;
            hdr <= 12'h000;
            isRead <= 1'b0;
            regIdx <= 5'h00;
            shift <= 16'h0000;
            wrPulse <= 1'b0;
            wrWord <= 16'h0000;
            mdioOut <= 1'b1;
            mdioOe <= 1'b0;
        end else begin
            mdcPrev <= mdc;
            wrPulse <= 1'b0;
            if (mdcRise) begin
                unique case (state)
                    S_PRE: begin
                        if (mdioIn) begin
                            ones <= (ones == PREAMBLE_ONES) ? ones : ones + 6'h01;
                        end else begin
                            if (ones == PREAMBLE_ONES) begin
                                state <= S_HDR;
                            end
                            ones <= 6'h00;
                            cnt <= 4'h0;
                        end
                    end
                    S_HDR: begin
                        hdr <= hdrFull[11:0];
                        cnt <= cnt + 4'h1;
                        if (cnt == HDR_LAST) begin
                            cnt <= 4'h0;
                            isRead <= (hdrOp == OP_READ);
                            regIdx <= hdrFull[4:0];
                            state <= hdrMine ? S_TA : S_PRE; // [RULE_02]
                        end
                    end
                    S_TA: begin
                        cnt <= cnt + 4'h1;
                        if (cnt == 4'h0) begin
                            // on a read, the second turnaround bit is ours to drive low
                            mdioOe <= isRead;
                            mdioOut <= ~isRead;
                        end else begin
                            cnt <= 4'h0;
                            state <= S_DAT;
                            mdioOut <= isRead ? bus.rdData[15] : 1'b1; // [RULE_01] [RULE_03]
                            shift <= {bus.rdData[14:0], 1'b0};
                        end
                    end
                    S_DAT: begin
                        cnt <= cnt + 4'h1;
                        if (isRead) begin
                            mdioOut <= shift[15];
                            shift <= {shift[14:0], 1'b0};
                        end else begin
                            shift <= {shift[14:0], mdioIn};
                        end
                        if (cnt == DATA_LAST) begin
                            state <= S_PRE;
                            mdioOe <= 1'b0;
                            mdioOut <= 1'b1;
                            wrPulse <= ~isRead;
                            wrWord <= {shift[14:0], mdioIn};
                        end
                    end
                endcase
            end
        end
    end
endmodule

// [core/epr_phy_regs.sv]
`timescale 1ns/1ps
// Contract
// (RULE_01) registers reachable memory-mapped and by serial frames
// (RULE_02) serial frames answered only at strapped address
// (RULE_03) serial 16 bits, mapped view zero-padded 32
// (RULE_04) indexes 0-6 and 31 decode fixed registers
// (RULE_05) bit meanings follow standard management register set
// (RULE_06) loader rewrites whole control after reset, reload
// (RULE_07) control bit 15 restores defaults, self-clears
// (RULE_08) bit 14 loops host transmit back to receive
// (RULE_09) bit 13 forces speed when negotiation off
// (RULE_10) bit 12 negotiation enable, default one, overrides forcing
// (RULE_11) bits 11, 10 are storage without effect
// (RULE_12) bit 9 recomputes negotiation results, self-clears
// (RULE_13) bit 8 forces duplex when negotiation off
// (RULE_14) bit 7 raises collision while host transmits
// (RULE_15) manager uses collision test only with loopback
// (RULE_16) bit 6 reads zero; bits 5-0 reserved
// (RULE_17) status always link up, no fault, no jabber
// (RULE_18) negotiation-complete clears on reset, sets shortly after
// (RULE_19) undecoded serial index reads zero, ignores writes
module epr_phy_regs (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire epr_pkg::phy_addr_t phyAddrStrap,
    input wire epr_pkg::csr_addr_t csrAddr,
    input wire logic csrRead,
    input wire logic csrWrite,
    input wire epr_pkg::word32_t csrWdata,
    output epr_pkg::word32_t csrRdata,
    output logic csrRdValid,
    input wire logic loaderWrite,
    input wire epr_pkg::word16_t loaderData,
    input wire logic mdc,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe,
    input wire logic hostTxEn,
    input wire epr_pkg::nib_t hostTxData,
    output logic hostRxDv,
    output epr_pkg::nib_t hostRxData,
    output logic hostCol,
    output logic fabricTxEn,
    output epr_pkg::nib_t fabricTxData,
    input wire logic fabricRxDv,
    input wire epr_pkg::nib_t fabricRxData,
    output logic linkSpeed100,
    output logic linkFullDuplex,
    output logic negotiationDone
);
    import epr_pkg::*;

    epr_mgmt_if mgmt ();

    // maps a serial index onto a storage slot; used by the serial path only, the mapped path goes through addrToSlot
    function automatic logic [3:0] indexToSlot(input phy_addr_t idx);
        logic [3:0] r;
        r = 4'h0;
        unique case (idx)
            IDX_CONTROL: r = {1'b1, SLOT_CONTROL}; // [RULE_04]
            IDX_STATE: r = {1'b1, SLOT_STATE};
            IDX_IDENT_HIGH: r = {1'b1, SLOT_IDENT_HIGH};
            IDX_IDENT_LOW: r = {1'b1, SLOT_IDENT_LOW};
            IDX_ADVERT: r = {1'b1, SLOT_ADVERT};
            IDX_PARTNER: r = {1'b1, SLOT_PARTNER};
            IDX_EXPANSION: r = {1'b1, SLOT_EXPANSION};
            IDX_SPECIAL: r = {1'b1, SLOT_SPECIAL};
            default: r = 4'h0;
        endcase
        return r;
    endfunction

    function automatic logic [3:0] addrToSlot(input csr_addr_t addr);
        logic [3:0] r;
        r = 4'h0;
        if (addr[1:0] == 2'b00 && addr >= OFF_CONTROL && addr <= OFF_SPECIAL) begin
            r = {1'b1, addr[4:2]};
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // stored state
    logic strapDone;
    phy_addr_t strapAddr;
    logic loopEn, speedBit, negEn, pwrDummy, isoDummy, duplexBit, colTest;
    word16_t identHigh, identLow, advert, special;
    logic negDone;
    logic [7:0] settleCnt;
    logic negSpeed100, negFull;

    ////////////////////////////////////////////////////////////////////////
    // read view
    wire word16_t controlWord = {1'b0, loopEn, speedBit, negEn, pwrDummy, isoDummy, 1'b0, duplexBit,
                                 colTest, 7'h00}; // [RULE_07] [RULE_12] [RULE_16]
    // fixed abilities: link up, no remote fault, no jabber
    wire word16_t stateWord = STATE_BASE | {10'h000, negDone, 5'h00}; // [RULE_17] [RULE_05]

    word16_t view [0:7];
    assign view[SLOT_CONTROL] = controlWord;
    assign view[SLOT_STATE] = stateWord;
    assign view[SLOT_IDENT_HIGH] = identHigh;
    assign view[SLOT_IDENT_LOW] = identLow;
    assign view[SLOT_ADVERT] = advert;
    assign view[SLOT_PARTNER] = PARTNER_ABILITY;
    assign view[SLOT_EXPANSION] = EXPANSION_VALUE;
    assign view[SLOT_SPECIAL] = special;

    wire [3:0] serSlot = indexToSlot(mgmt.index);
    wire [3:0] csrSlot = addrToSlot(csrAddr);
    assign mgmt.rdData = serSlot[3] ? view[serSlot[2:0]] : 16'h0000; // [RULE_19]
    assign mgmt.strapAddr = strapAddr;
    assign mgmt.strapValid = strapDone;

    ////////////////////////////////////////////////////////////////////////
    // write arbitration: loader, then memory-mapped, then serial
    wire csrWrHit = csrWrite & csrSlot[3];
    wire serWrHit = mgmt.wrStrobe & serSlot[3]; // [RULE_19]
    wire anyWr = loaderWrite | csrWrHit | serWrHit;
    wire slot_t wrSlot = loaderWrite ? SLOT_CONTROL : (csrWrHit ? csrSlot[2:0] : serSlot[2:0]);
    // upper half of a mapped write is dropped, reserved bits read zero
    wire word16_t wrWord = loaderWrite ? loaderData : (csrWrHit ? csrWdata[15:0] : mgmt.wrData); // [RULE_03] [RULE_06]
    wire ctlWr = anyWr && (wrSlot == SLOT_CONTROL);
    wire softReset = ctlWr & wrWord[CTL_SOFT_RESET]; // [RULE_07]
    wire negRestart = ctlWr & wrWord[CTL_NEG_RESTART] & ~softReset; // [RULE_12]

    // emulated negotiation: best mode common to both advertisements
    wire word16_t common = advert & PARTNER_ABILITY;
    wire next_negSpeed100 = common[ADV_100_FULL] | common[ADV_100_HALF];
    wire next_negFull = common[ADV_100_FULL] | (~common[ADV_100_HALF] & common[ADV_10_FULL]);
    wire next_speed = negEn ? negSpeed100 : speedBit; // [RULE_09] [RULE_10]
    wire next_full = negEn ? negFull : duplexBit; // [RULE_13] [RULE_10]

    ////////////////////////////////////////////////////////////////////////
    // strap is captured once reset has been released
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            strapDone <= 1'b0;
            strapAddr <= 5'h00;
        end else if (!strapDone) begin
            strapDone <= 1'b1;
            strapAddr <= phyAddrStrap; // [RULE_02]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n || softReset) begin
            loopEn <= CONTROL_RESET[CTL_LOOP]; // [RULE_07]
            speedBit <= CONTROL_RESET[CTL_SPEED];
            negEn <= CONTROL_RESET[CTL_NEG_EN]; // [RULE_10]
            pwrDummy <= CONTROL_RESET[CTL_PWR_DOWN];
            isoDummy <= CONTROL_RESET[CTL_ISOLATE];
            duplexBit <= CONTROL_RESET[CTL_DUPLEX];
            colTest <= CONTROL_RESET[CTL_COL_TEST];
            identHigh <= IDENT_HIGH_RESET;
            identLow <= IDENT_LOW_RESET;
            advert <= ADVERT_RESET;
            special <= SPECIAL_RESET;
        end else if (anyWr) begin
            unique case (wrSlot)
                SLOT_CONTROL: begin
                    loopEn <= wrWord[CTL_LOOP]; // [RULE_06]
                    speedBit <= wrWord[CTL_SPEED];
                    negEn <= wrWord[CTL_NEG_EN];
                    pwrDummy <= wrWord[CTL_PWR_DOWN]; // [RULE_11]
                    isoDummy <= wrWord[CTL_ISOLATE]; // [RULE_11]
                    duplexBit <= wrWord[CTL_DUPLEX];
                    colTest <= wrWord[CTL_COL_TEST];
                end
                SLOT_IDENT_HIGH: identHigh <= wrWord;
                SLOT_IDENT_LOW: identLow <= wrWord;
                SLOT_ADVERT: advert <= wrWord;
                SLOT_SPECIAL: special <= wrWord;
                SLOT_STATE, SLOT_PARTNER, SLOT_EXPANSION: begin
                end
            endcase
        end
    end

    // completion drops on reset or restart and returns after the settle time
    always_ff @(posedge ref_clk) begin
        if (!reset_n || softReset || negRestart) begin
            negDone <= 1'b0; // [RULE_18]
            settleCnt <= 8'h00;
        end else if (!negDone) begin
            settleCnt <= settleCnt + 8'h01;
            if (settleCnt == NEG_SETTLE_CYC - 8'h01) begin
                negDone <= 1'b1; // [RULE_18]
            end
        end
    end

    // results are only refreshed when negotiation finishes
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            negSpeed100 <= 1'b0;
            negFull <= 1'b0;
        end else if (!negDone && settleCnt == NEG_SETTLE_CYC - 8'h01) begin
            negSpeed100 <= next_negSpeed100; // [RULE_12]
            negFull <= next_negFull;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host- and fabric-facing outputs
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            csrRdata <= 32'h0000_0000;
            csrRdValid <= 1'b0;
            linkSpeed100 <= 1'b0;
            linkFullDuplex <= 1'b0;
            negotiationDone <= 1'b0;
            hostRxDv <= 1'b0;
            hostRxData <= 4'h0;
            hostCol <= 1'b0;
            fabricTxEn <= 1'b0;
            fabricTxData <= 4'h0;
        end else begin
            csrRdValid <= csrRead;
            if (csrRead) begin
                csrRdata <= {16'h0000, csrSlot[3] ? view[csrSlot[2:0]] : 16'h0000}; // [RULE_01] [RULE_03]
            end
            linkSpeed100 <= next_speed;
            linkFullDuplex <= next_full;
            negotiationDone <= negDone;
            hostRxDv <= loopEn ? hostTxEn : fabricRxDv; // [RULE_08]
            hostRxData <= loopEn ? hostTxData : fabricRxData; // [RULE_08]
            fabricTxEn <= hostTxEn & ~loopEn; // [RULE_08]
            fabricTxData <= loopEn ? 4'h0 : hostTxData;
            // test mode is meant to run with loopback on; not enforced here
            hostCol <= colTest & hostTxEn; // [RULE_14] [RULE_15]
        end
    end

    epr_mdio_serial u_serial (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .mdc(mdc),
        .mdioIn(mdioIn),
        .mdioOut(mdioOut),
        .mdioOe(mdioOe),
        .bus(mgmt.serial)
    );
endmodule

// [test/epr_regs_checker.sv]
`timescale 1ns/1ps
module epr_regs_checker (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic csrRead,
    input wire epr_pkg::word32_t csrRdata,
    input wire logic csrRdValid,
    input wire logic mdioOut,
    input wire logic mdioOe,
    input wire logic hostTxEn,
    input wire epr_pkg::nib_t hostTxData,
    input wire logic hostRxDv,
    input wire epr_pkg::nib_t hostRxData,
    input wire logic hostCol,
    input wire logic fabricTxEn,
    input wire epr_pkg::nib_t fabricTxData,
    input wire logic negotiationDone
);
    import epr_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    rd_answer_a: assert property (csrRead |=> csrRdValid)
        else $error("read not answered");
    rd_spurious_a: assert property (!csrRead |=> !csrRdValid)
        else $error("answer without read");
    rd_hold_a: assert property (!csrRead |=> $stable(csrRdata))
        else $error("read data moved");
    pad_zero_a: assert property (csrRdValid |-> csrRdata[31:16] == 16'h0000)
        else $error("upper half not zero");
    idle_high_a: assert property (!mdioOe |-> mdioOut)
        else $error("released data not high");
    turn_low_a: assert property ($rose(mdioOe) |-> !mdioOut)
        else $error("turnaround not low");
    loop_back_a: assert property ($past(hostTxEn) && !fabricTxEn |-> hostRxDv && hostRxData == $past(hostTxData))
        else $error("held frame not looped");
    fwd_data_a: assert property (fabricTxEn |-> $past(hostTxEn) && fabricTxData == $past(hostTxData))
        else $error("fabric data wrong");
    col_cause_a: assert property (hostCol |-> $past(hostTxEn))
        else $error("collision without transmit");
    neg_settle_a: assert property ($rose(reset_n) |-> !negotiationDone ##[3:7] negotiationDone)
        else $error("negotiation did not settle");
    cover property (hostCol);
    cover property ($rose(mdioOe));
    cover property (csrRdValid && csrRdata[15:0] == 16'h1000);
endmodule

// [test/epr_mgmt_master.sv]
`timescale 1ns/1ps
module epr_mgmt_master (
    input wire logic ref_clk,
    input wire logic mdioOut,
    input wire logic mdioOe,
    output logic mdc,
    output wire logic mdioIn
);
    import epr_pkg::*;
    logic drvOe = 1'h0;
    logic drvVal = 1'h1;
    // open-drain line with pull-up, so a released wire reads high
    assign mdioIn = (mdioOe ? mdioOut : 1'h1) & (drvOe ? drvVal : 1'h1);
    initial mdc = 1'h0;
    ////////////////////////////////////////////////////////////////////////////////
    // one bit: data changes with mdc low, sampled just before the rise
    task automatic tick(input logic oe, v, output logic smp);
        @(negedge ref_clk);
        mdc = 1'h0;
        drvOe = oe;
        drvVal = v;
        repeat (3) @(negedge ref_clk);
        smp = mdioIn;
        mdc = 1'h1;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic frame(input logic [1:0] op, input phy_addr_t pa, ra, word16_t wd,
        output word16_t rd, logic ta);
        logic s;
        logic [13:0] hdr;
        hdr = {2'h1, op, pa, ra};
        repeat (32) tick(1'h1, 1'h1, s);
        for (int i = 13; i >= 0; i--) tick(1'h1, hdr[i], s);
        tick(op == OP_WRITE, 1'h1, s);
        tick(op == OP_WRITE, 1'h0, ta);
        for (int i = 15; i >= 0; i--) begin
            tick(op == OP_WRITE, wd[i], s);
            rd[i] = s;
        end
        repeat (2) tick(1'h0, 1'h1, s);
    endtask
endmodule

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import epr_pkg::*;
    localparam phy_addr_t STRAP = 5'h01;
    logic ref_clk, reset_n, csrRead, csrWrite, csrRdValid, loaderWrite, mdc, mdioOut, mdioOe;
    logic hostTxEn, hostRxDv, hostCol, fabricTxEn, fabricRxDv, linkSpeed100, linkFullDuplex, negotiationDone;
    wire logic mdioIn;
    csr_addr_t csrAddr;
    word32_t csrWdata, csrRdata;
    word16_t loaderData;
    nib_t hostTxData, hostRxData, fabricTxData, fabricRxData;
    int numErrors = 0, checksDone = 0, cycles = 0;
    epr_phy_regs u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .phyAddrStrap(STRAP), .csrAddr(csrAddr),
        .csrRead(csrRead), .csrWrite(csrWrite), .csrWdata(csrWdata), .csrRdata(csrRdata),
        .csrRdValid(csrRdValid), .loaderWrite(loaderWrite), .loaderData(loaderData), .mdc(mdc),
        .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe), .hostTxEn(hostTxEn), .hostTxData(hostTxData),
        .hostRxDv(hostRxDv), .hostRxData(hostRxData), .hostCol(hostCol), .fabricTxEn(fabricTxEn),
        .fabricTxData(fabricTxData), .fabricRxDv(fabricRxDv), .fabricRxData(fabricRxData),
        .linkSpeed100(linkSpeed100), .linkFullDuplex(linkFullDuplex), .negotiationDone(negotiationDone));
    epr_mgmt_master u_mgmt (.ref_clk(ref_clk), .mdioOut(mdioOut), .mdioOe(mdioOe), .mdc(mdc), .mdioIn(mdioIn));
    initial begin
        ref_clk = 1'h0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            numErrors++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (numErrors == 0 && checksDone > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string n, word32_t e, word32_t s);
        checksDone++;
        if (s !== e) begin
            numErrors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic csr_wr(input csr_addr_t a, word32_t d);
        @(negedge ref_clk);
        csrAddr = a;
        csrWdata = d;
        csrWrite = 1'h1;
        @(negedge ref_clk);
        csrWrite = 1'h0;
    endtask
    task automatic csr_rd(input csr_addr_t a, output word32_t d);
        @(negedge ref_clk);
        csrAddr = a;
        csrRead = 1'h1;
        @(negedge ref_clk);
        csrRead = 1'h0;
        d = (csrRdValid === 1'h1) ? csrRdata : 32'hFFFF_FFFF;
    endtask
    function automatic word32_t link3();
        return {29'h0, negotiationDone, linkSpeed100, linkFullDuplex};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_defaults();
        word32_t r;
        repeat (8) @(negedge ref_clk);
        csr_rd(OFF_CONTROL, r);
        chk("control default", 32'h0000_1000, r);
        csr_rd(OFF_STATE, r);
        chk("status", 32'h0000_782D, r);
        chk("negotiated link", 32'h7, link3());
    endtask
    task automatic t_forcing();
        word32_t r;
        word32_t w [4], e [4];
        w = '{32'hFFFF_6DFF, 32'h0000_2000, 32'h0000_0100, 32'h0000_1000};
        e = '{32'h7, 32'h6, 32'h5, 32'h7};
        csr_wr(OFF_CONTROL, w[0]);
        csr_rd(OFF_CONTROL, r);
        chk("control fields", 32'h0000_6D80, r);
        for (int k = 0; k < 4; k++) begin
            csr_wr(OFF_CONTROL, w[k]);
            repeat (8) @(negedge ref_clk);
            chk("link mode", e[k], link3());
        end
    endtask
    task automatic t_restart();
        word32_t r;
        csr_wr(OFF_CONTROL, 32'h0000_1200);
        csr_rd(OFF_STATE, r);
        chk("status rerun", 32'h0000_780D, r);
        csr_rd(OFF_CONTROL, r);
        chk("restart cleared", 32'h0000_1000, r);
        repeat (8) @(negedge ref_clk);
        csr_rd(OFF_STATE, r);
        chk("status settled", 32'h0000_782D, r);
    endtask
    task automatic t_datapath();
        csr_wr(OFF_CONTROL, 32'h0000_5080);
        @(negedge ref_clk);
        hostTxEn = 1'h1;
        hostTxData = 4'hA;
        fabricRxDv = 1'h1;
        fabricRxData = 4'h5;
        @(negedge ref_clk);
        chk("looped path", 32'h69, {25'h0, hostRxDv, hostRxData, fabricTxEn, hostCol});
        csr_wr(OFF_CONTROL, 32'h0000_1C00);
        @(negedge ref_clk);
        chk("fwd path", 32'h574, {21'h0, hostRxDv, hostRxData, fabricTxEn, fabricTxData, hostCol});
        hostTxEn = 1'h0;
        fabricRxDv = 1'h0;
    endtask
    task automatic t_loader_soft();
        word32_t r;
        @(negedge ref_clk);
        loaderWrite = 1'h1;
        loaderData = 16'h2100;
        csrAddr = OFF_CONTROL;
        csrWdata = 32'h0000_4000;
        csrWrite = 1'h1;
        @(negedge ref_clk);
        loaderWrite = 1'h0;
        csrWrite = 1'h0;
        csr_rd(OFF_CONTROL, r);
        chk("loader word", 32'h0000_2100, r);
        csr_wr(OFF_IDENT_HIGH, 32'hABCD_1234);
        csr_rd(OFF_IDENT_HIGH, r);
        chk("ident stored", 32'h0000_1234, r);
        csr_wr(OFF_CONTROL, 32'h0000_C000);
        csr_rd(OFF_CONTROL, r);
        chk("control soft reset", 32'h0000_1000, r);
        csr_rd(OFF_IDENT_HIGH, r);
        chk("ident soft reset", 32'h0, r);
        csr_rd(9'h1E0, r);
        chk("unmapped", 32'h0, r);
    endtask
    task automatic t_serial();
        word16_t want [8];
        word16_t d;
        logic ta;
        word32_t r;
        want = '{16'h1000, 16'h782D, 16'h0000, 16'h0000, 16'h01E1, 16'h01E1, 16'h0001, 16'h0000};
        for (int k = 0; k < 8; k++) begin
            u_mgmt.frame(OP_READ, STRAP, (k < 7) ? phy_addr_t'(k) : IDX_SPECIAL, 16'h0000, d, ta);
            chk("serial word", {16'h0, want[k]}, {15'h0, ta, d});
        end
        u_mgmt.frame(OP_WRITE, STRAP, IDX_ADVERT, 16'h0061, d, ta);
        csr_rd(OFF_ADVERT, r);
        chk("advert mapped", 32'h0000_0061, r);
        u_mgmt.frame(OP_WRITE, STRAP, IDX_CONTROL, 16'h1200, d, ta);
        repeat (10) @(negedge ref_clk);
        chk("renegotiated", 32'h5, link3());
        u_mgmt.frame(OP_READ, 5'h02, IDX_CONTROL, 16'h0000, d, ta);
        chk("foreign read", 32'h0001_FFFF, {15'h0, ta, d});
        u_mgmt.frame(OP_WRITE, 5'h02, IDX_SPECIAL, 16'hBEEF, d, ta);
        csr_rd(OFF_SPECIAL, r);
        chk("foreign write", 32'h0, r);
        u_mgmt.frame(OP_WRITE, STRAP, 5'h07, 16'hFFFF, d, ta);
        u_mgmt.frame(OP_READ, STRAP, 5'h07, 16'h0000, d, ta);
        chk("undecoded", 32'h0, {15'h0, ta, d});
    endtask
    initial begin
        reset_n = 1'h0;
        csrAddr = OFF_CONTROL;
        csrRead = 1'h0;
        csrWrite = 1'h0;
        csrWdata = 32'h0;
        loaderWrite = 1'h0;
        loaderData = 16'h0;
        hostTxEn = 1'h0;
        hostTxData = 4'h0;
        fabricRxDv = 1'h0;
        fabricRxData = 4'h0;
        repeat (6) @(negedge ref_clk);
        reset_n = 1'h1;
        t_defaults();
        t_forcing();
        t_restart();
        t_datapath();
        t_loader_soft();
        t_serial();
        end_sim();
    end
endmodule
bind epr_phy_regs epr_regs_checker u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .csrRead(csrRead),
    .csrRdata(csrRdata), .csrRdValid(csrRdValid), .mdioOut(mdioOut), .mdioOe(mdioOe), .hostTxEn(hostTxEn),
    .hostTxData(hostTxData), .hostRxDv(hostRxDv), .hostRxData(hostRxData), .hostCol(hostCol),
    .fabricTxEn(fabricTxEn), .fabricTxData(fabricTxData), .negotiationDone(negotiationDone));
